// file: include/serial_access_pkg.sv
// Constants, state codes and address-byte decoding for the serial register access front end.
// Assumes a single 40 MHz clock; no timescale here.
// Summary of operation
// - I2C read shifts bytes from subaddressed register; master acks all but last.
// - Address byte bits 6:3 select the internal register; bit 0 is ignored.
// - Bits 2:1 select channel: 00 first, 01 second, 10 and 11 reserved.
// - SPI address bit 7 gives direction: 1 read, 0 write; unused on I2C.
// - SPI register read drives eight data bits MSB first right after the address.
// - SPI write to register 0000 bursts bytes into transmit FIFO until the end.
// - SPI read of register 0000 bursts receive FIFO bytes while master clocks.
// - I2C write stores bytes after subaddress in order until the stop condition.
package serial_access_pkg;
  localparam int BYTE_W = 8;
  localparam int DIR_BIT = 7;
  localparam int REG_MSB = 6;
  localparam int REG_LSB = 3;
  localparam int CHAN_MSB = 2;
  localparam int CHAN_LSB = 1;
  localparam int REG_W = 4;
  localparam int CHAN_W = 2;
  localparam int DEV_ADDR_W = 7;
  localparam int ITEM_W = CHAN_W + REG_W + BYTE_W;
  localparam int FIFO_DEPTH = 32;
  localparam logic [1:0] CHAN_FIRST = 2'h0;
  localparam logic [1:0] CHAN_SECOND = 2'h1;
  localparam logic [3:0] REG_FIFO = 4'h0;
  localparam logic [3:0] CNT_LAST = 4'h7;
  localparam logic [3:0] CNT_ACK = 4'h8;
  localparam logic [3:0] CNT_DONE = 4'h9;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [2:0] SPI_LAST = 3'h7;
  localparam logic [2:0] MSB_IDX = 3'h7;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  typedef enum logic [2:0] {
    I2C_IDLE = 3'b000,
    I2C_DEV  = 3'b001,
    I2C_SUB  = 3'b010,
    I2C_WR   = 3'b011,
    I2C_RD   = 3'b100,
    I2C_HOLD = 3'b101
  } i2c_state_t;

  function automatic logic [3:0] reg_of(input logic [7:0] b);
    reg_of = b[REG_MSB:REG_LSB];
  endfunction

  function automatic logic [1:0] chan_of(input logic [7:0] b);
    chan_of = b[CHAN_MSB:CHAN_LSB];
  endfunction

  function automatic logic chan_ok(input logic [1:0] c);
    chan_ok = (c == CHAN_FIRST) || (c == CHAN_SECOND);
  endfunction
endpackage

// file: hw/sync_fifo.sv
// Synchronous FIFO with a registered output stage.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module sync_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 32
) (
  input wire logic i_ref_clk, // Clock
  input wire logic i_rst, // Synchronous reset
  input wire logic i_valid, // Write request
  input wire logic [WIDTH-1:0] i_data, // Write data
  output logic o_ready, // Room for a write
  output logic o_valid, // Output word present
  output logic [WIDTH-1:0] o_data, // Output word
  input wire logic i_ready // Drain side accepts
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic valid_r, valid_nxt;
  logic [WIDTH-1:0] data_r, data_nxt;
  logic push, pop;

  always_comb
  begin
    push = i_valid && (cnt_r != FULL_CNT);
    pop = (cnt_r != '0) && (!valid_r || i_ready);
    wr_ptr_nxt = push ? ((wr_ptr_r == LAST_IDX) ? '0 : wr_ptr_r + 1'b1) : wr_ptr_r;
    rd_ptr_nxt = pop ? ((rd_ptr_r == LAST_IDX) ? '0 : rd_ptr_r + 1'b1) : rd_ptr_r;
    cnt_nxt = cnt_r + CW'(push) - CW'(pop);
    valid_nxt = pop ? 1'b1 : (i_ready ? 1'b0 : valid_r);
    data_nxt = pop ? mem[rd_ptr_r] : data_r;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (push)
    begin
      mem[wr_ptr_r] <= i_data;
    end
    if (i_rst)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
      valid_r <= 1'b0;
      data_r <= '0;
    end
    else
    begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      cnt_r <= cnt_nxt;
      valid_r <= valid_nxt;
      data_r <= data_nxt;
    end
  end

  assign o_ready = (cnt_r != FULL_CNT);
  assign o_valid = valid_r;
  assign o_data = data_r;
endmodule // sync_fifo

// file: hw/serial_host_access.sv
// I2C / SPI slave front end that turns host transfers into register reads and writes.
// Assumes all pins are synchronous to i_ref_clk and much slower than it.
`timescale 1ns/1ps
module serial_host_access #(
  parameter int FIFO_DEPTH = serial_access_pkg::FIFO_DEPTH
) (
  input wire logic i_ref_clk, // 40 MHz clock
  input wire logic i_rst, // Synchronous reset, active high
  input wire logic i_spi_mode, // 1 selects SPI, 0 selects I2C
  input wire logic [6:0] i_dev_addr, // I2C device address
  input wire logic i_scl, // I2C clock
  input wire logic i_sda, // I2C data in
  output logic o_sda, // I2C data out, always low
  output logic o_sda_oe_n, // Low pulls SDA low
  input wire logic i_sclk, // SPI clock
  input wire logic i_cs_n, // SPI chip select
  input wire logic i_mosi, // SPI data in
  output logic o_miso, // SPI data out
  output logic o_rd_req, // Read request pulse
  output logic [3:0] o_rd_reg, // Read register selector
  output logic [1:0] o_rd_chan, // Read channel_selector
  input wire logic i_rd_valid, // Read data strobe
  input wire logic [7:0] i_rd_data, // Read data
  output logic o_wr_valid, // Write word present
  output logic [3:0] o_wr_reg, // Write register selector
  output logic [1:0] o_wr_chan, // Write channel_selector
  output logic [7:0] o_wr_data, // Write data
  input wire logic i_wr_ready, // Write word accepted
  output logic o_overrun // SPI write byte dropped
);
  serial_access_pkg::i2c_state_t ist_r, ist_nxt;
  logic scl_q, sda_q, sclk_q;
  logic [3:0] icnt_r, icnt_nxt;
  logic [7:0] ishift_r, ishift_nxt;
  logic ack_r, ack_nxt;
  logic oe_n_r, oe_n_nxt;
  logic [2:0] scnt_r, scnt_nxt;
  logic [7:0] sshift_r, sshift_nxt;
  logic sdata_r, sdata_nxt, sread_r, sread_nxt, sfirst_r, sfirst_nxt;
  logic miso_r, miso_nxt;
  logic [3:0] reg_r, reg_nxt;
  logic [1:0] chan_r, chan_nxt;
  logic rd_req_r, rd_req_nxt;
  logic [7:0] rd_byte_r, rd_byte_nxt;
  logic overrun_r, overrun_nxt;
  logic push;
  logic [7:0] push_byte;
  logic fifo_ready;
  logic scl_rise, scl_fall, i2c_start, i2c_stop, sclk_rise, sclk_fall;
  logic req_rd;
  logic [7:0] b;
  localparam logic [7:0] BYTE_ZERO_F = serial_access_pkg::BYTE_ZERO;

  assign scl_rise = i_scl && !scl_q;
  assign scl_fall = !i_scl && scl_q;
  assign i2c_start = i_scl && scl_q && sda_q && !i_sda;
  assign i2c_stop = i_scl && scl_q && !sda_q && i_sda;
  assign sclk_rise = i_sclk && !sclk_q;
  assign sclk_fall = !i_sclk && sclk_q;

  always_comb
  begin
    ist_nxt = ist_r;
    icnt_nxt = icnt_r;
    ishift_nxt = ishift_r;
    ack_nxt = ack_r;
    oe_n_nxt = oe_n_r;
    scnt_nxt = scnt_r;
    sshift_nxt = sshift_r;
    sdata_nxt = sdata_r;
    sread_nxt = sread_r;
    sfirst_nxt = sfirst_r;
    miso_nxt = miso_r;
    reg_nxt = reg_r;
    chan_nxt = chan_r;
    rd_req_nxt = 1'b0;
    rd_byte_nxt = i_rd_valid ? i_rd_data : rd_byte_r;
    overrun_nxt = 1'b0;
    push = 1'b0;
    push_byte = BYTE_ZERO_F;
    req_rd = 1'b0;
    b = BYTE_ZERO_F;
    if (!i_spi_mode)
    begin
      b = {ishift_r[6:0], i_sda};
      case (ist_r)
        serial_access_pkg::I2C_DEV, serial_access_pkg::I2C_SUB, serial_access_pkg::I2C_WR:
        begin
          if (scl_rise && icnt_r < serial_access_pkg::CNT_ACK)
          begin
            ishift_nxt = b;
            icnt_nxt = icnt_r + 1'b1;
            if (icnt_r == serial_access_pkg::CNT_LAST)
            begin
              if (ist_r == serial_access_pkg::I2C_DEV)
              begin
                ack_nxt = (b[7:1] == i_dev_addr);
                req_rd = (b[7:1] == i_dev_addr) && b[0];
              end
              else if (ist_r == serial_access_pkg::I2C_SUB)
              begin
                ack_nxt = 1'b1;
                reg_nxt = serial_access_pkg::reg_of(b);
                chan_nxt = serial_access_pkg::chan_of(b);
              end
              else
              begin
                ack_nxt = fifo_ready;
                push = fifo_ready && serial_access_pkg::chan_ok(chan_r);
                push_byte = b;
              end
            end
          end
          else if (scl_fall && icnt_r == serial_access_pkg::CNT_ACK)
          begin
            icnt_nxt = serial_access_pkg::CNT_DONE;
            oe_n_nxt = !ack_r;
          end
          else if (scl_fall && icnt_r == serial_access_pkg::CNT_DONE)
          begin
            icnt_nxt = serial_access_pkg::CNT_ZERO;
            oe_n_nxt = 1'b1;
            if (ist_r == serial_access_pkg::I2C_DEV)
            begin
              if (!ack_r)
              begin
                ist_nxt = serial_access_pkg::I2C_HOLD;
              end
              else if (ishift_r[0])
              begin
                ist_nxt = serial_access_pkg::I2C_RD;
                oe_n_nxt = rd_byte_r[serial_access_pkg::MSB_IDX];
              end
              else
              begin
                ist_nxt = serial_access_pkg::I2C_SUB;
              end
            end
            else
            begin
              ist_nxt = serial_access_pkg::I2C_WR;
            end
          end
        end
        serial_access_pkg::I2C_RD:
        begin
          if (scl_rise)
          begin
            if (icnt_r == serial_access_pkg::CNT_ACK)
            begin
              if (i_sda)
              begin
                ist_nxt = serial_access_pkg::I2C_HOLD;
              end
              else
              begin
                icnt_nxt = serial_access_pkg::CNT_ZERO;
                req_rd = 1'b1;
              end
            end
            else
            begin
              icnt_nxt = icnt_r + 1'b1;
            end
          end
          else if (scl_fall)
          begin
            oe_n_nxt = (icnt_r < serial_access_pkg::CNT_ACK) ?
              rd_byte_r[serial_access_pkg::MSB_IDX - icnt_r[2:0]] : 1'b1;
          end
        end
        default:
        begin
          oe_n_nxt = 1'b1;
        end
      endcase
      if (i2c_stop)
      begin
        ist_nxt = serial_access_pkg::I2C_IDLE;
        oe_n_nxt = 1'b1;
        push = 1'b0;
        req_rd = 1'b0;
      end
      else if (i2c_start)
      begin
        ist_nxt = serial_access_pkg::I2C_DEV;
        icnt_nxt = serial_access_pkg::CNT_ZERO;
        oe_n_nxt = 1'b1;
        push = 1'b0;
        req_rd = 1'b0;
      end
    end
    else
    begin
      ist_nxt = serial_access_pkg::I2C_IDLE;
      oe_n_nxt = 1'b1;
      b = {sshift_r[6:0], i_mosi};
      if (i_cs_n)
      begin
        scnt_nxt = '0;
        sdata_nxt = 1'b0;
        sfirst_nxt = 1'b0;
      end
      else if (sclk_rise)
      begin
        sshift_nxt = b;
        scnt_nxt = scnt_r + 1'b1;
        if (scnt_r == serial_access_pkg::SPI_LAST)
        begin
          if (!sdata_r)
          begin
            sdata_nxt = 1'b1;
            sread_nxt = b[serial_access_pkg::DIR_BIT];
            reg_nxt = serial_access_pkg::reg_of(b);
            chan_nxt = serial_access_pkg::chan_of(b);
            req_rd = b[serial_access_pkg::DIR_BIT];
          end
          else if (!sread_r)
          begin
            if (reg_r == serial_access_pkg::REG_FIFO || !sfirst_r)
            begin
              push = fifo_ready && serial_access_pkg::chan_ok(chan_r);
              overrun_nxt = !fifo_ready && serial_access_pkg::chan_ok(chan_r);
              push_byte = b;
            end
            sfirst_nxt = 1'b1;
          end
          else if (reg_r == serial_access_pkg::REG_FIFO)
          begin
            req_rd = 1'b1;
          end
        end
      end
      else if (sclk_fall && sdata_r && sread_r)
      begin
        miso_nxt = rd_byte_r[serial_access_pkg::MSB_IDX - scnt_r];
      end
    end
    if (req_rd)
    begin
      if (serial_access_pkg::chan_ok(chan_nxt))
      begin
        rd_req_nxt = 1'b1;
      end
      else
      begin
        rd_byte_nxt = BYTE_ZERO_F;
      end
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      sclk_q <= 1'b0;
      ist_r <= serial_access_pkg::I2C_IDLE;
      icnt_r <= serial_access_pkg::CNT_ZERO;
      ishift_r <= serial_access_pkg::BYTE_ZERO;
      ack_r <= 1'b0;
      oe_n_r <= 1'b1;
      scnt_r <= '0;
      sshift_r <= serial_access_pkg::BYTE_ZERO;
      sdata_r <= 1'b0;
      sread_r <= 1'b0;
      sfirst_r <= 1'b0;
      miso_r <= 1'b0;
      reg_r <= serial_access_pkg::REG_FIFO;
      chan_r <= serial_access_pkg::CHAN_FIRST;
      rd_req_r <= 1'b0;
      rd_byte_r <= serial_access_pkg::BYTE_ZERO;
      overrun_r <= 1'b0;
    end
    else
    begin
      scl_q <= i_scl;
      sda_q <= i_sda;
      sclk_q <= i_sclk;
      ist_r <= ist_nxt;
      icnt_r <= icnt_nxt;
      ishift_r <= ishift_nxt;
      ack_r <= ack_nxt;
      oe_n_r <= oe_n_nxt;
      scnt_r <= scnt_nxt;
      sshift_r <= sshift_nxt;
      sdata_r <= sdata_nxt;
      sread_r <= sread_nxt;
      sfirst_r <= sfirst_nxt;
      miso_r <= miso_nxt;
      reg_r <= reg_nxt;
      chan_r <= chan_nxt;
      rd_req_r <= rd_req_nxt;
      rd_byte_r <= rd_byte_nxt;
      overrun_r <= overrun_nxt;
    end
  end

  // Write path: register writes queue here; when it is full, I2C bytes are NACKed and SPI bytes are dropped with o_overrun
  sync_fifo #(
    .WIDTH(serial_access_pkg::ITEM_W),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_valid(push),
    .i_data({chan_r, reg_r, push_byte}),
    .o_ready(fifo_ready),
    .o_valid(o_wr_valid),
    .o_data({o_wr_chan, o_wr_reg, o_wr_data}),
    .i_ready(i_wr_ready)
  );

  assign o_sda = 1'b0;
  assign o_sda_oe_n = oe_n_r;
  assign o_miso = miso_r;
  assign o_rd_req = rd_req_r;
  assign o_rd_reg = reg_r;
  assign o_rd_chan = chan_r;
  assign o_overrun = overrun_r;
endmodule // serial_host_access

// file: bench/serial_host_monitor.sv
// Checker for the serial register access front end, bound to its top module.
// Assumes every pin is sampled on i_ref_clk and reset is synchronous.
`timescale 1ns/1ps
module serial_host_monitor (
  input wire logic i_ref_clk, // Clock
  input wire logic i_rst, // Reset
  input wire logic i_spi_mode, // Bus select
  input wire logic i_sclk, // SPI clock
  input wire logic i_scl, // I2C clock
  input wire logic i_cs_n, // SPI select
  input wire logic o_sda, // SDA value
  input wire logic o_sda_oe_n, // SDA enable
  input wire logic o_miso, // SPI out
  input wire logic o_rd_req, // Read request
  input wire logic [1:0] o_rd_chan, // Read channel
  input wire logic o_wr_valid, // Word present
  input wire logic [3:0] o_wr_reg, // Word register
  input wire logic [1:0] o_wr_chan, // Word channel
  input wire logic [7:0] o_wr_data, // Word data
  input wire logic i_wr_ready, // Word taken
  input wire logic o_overrun // Byte dropped
);
  default clocking dc @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);
  sequence s_stall;
    o_wr_valid && !i_wr_ready;
  endsequence
  sequence s_hold;
    o_wr_valid && $stable({o_wr_reg, o_wr_chan, o_wr_data});
  endsequence
  sequence s_sclk_fell;
    $past(i_sclk, 2) && !$past(i_sclk, 1);
  endsequence
  property p_wr_hold;
    s_stall |=> s_hold;
  endproperty
  property p_miso_fall;
    $changed(o_miso) && !i_cs_n && !$past(i_cs_n, 3) |-> s_sclk_fell;
  endproperty
  property p_rd_pulse;
    o_rd_req |=> !o_rd_req;
  endproperty
  property p_rd_chan;
    o_rd_req |-> !o_rd_chan[1];
  endproperty
  property p_wr_chan;
    o_wr_valid |-> !o_wr_chan[1];
  endproperty
  property p_rd_frame;
    o_rd_req && i_spi_mode |-> !i_cs_n [*3];
  endproperty
  property p_ovr;
    o_overrun |-> i_spi_mode && o_wr_valid;
  endproperty
  property p_sda_spi;
    i_spi_mode && $past(i_spi_mode, 2) |-> o_sda_oe_n;
  endproperty
  // SDA drive may only move while SCL has been low for a sample
  property p_sda_low;
    $changed(o_sda_oe_n) |-> !o_sda && !i_scl && !$past(i_scl);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("word moved while stalled");
  a_miso_fall: assert property (p_miso_fall) else $error("miso moved off a fall");
  a_rd_pulse: assert property (p_rd_pulse) else $error("read request too long");
  a_rd_chan: assert property (p_rd_chan) else $error("read of reserved channel");
  a_wr_chan: assert property (p_wr_chan) else $error("word of reserved channel");
  a_rd_frame: assert property (p_rd_frame) else $error("read outside frame");
  a_ovr: assert property (p_ovr) else $error("drop without full buffer");
  a_sda_spi: assert property (p_sda_spi) else $error("sda driven in spi mode");
  a_sda_low: assert property (p_sda_low) else $error("sda moved while scl high");
endmodule // serial_host_monitor
bind serial_host_access serial_host_monitor u_mon (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
  .i_spi_mode(i_spi_mode), .i_scl(i_scl), .i_sclk(i_sclk), .i_cs_n(i_cs_n), .o_sda(o_sda),
  .o_sda_oe_n(o_sda_oe_n),
  .o_miso(o_miso), .o_rd_req(o_rd_req), .o_rd_chan(o_rd_chan), .o_wr_valid(o_wr_valid),
  .o_wr_reg(o_wr_reg), .o_wr_chan(o_wr_chan), .o_wr_data(o_wr_data), .i_wr_ready(i_wr_ready),
  .o_overrun(o_overrun));

// file: bench/serial_host_master.sv
// Host bus master model driving SPI mode 0 or I2C pins from tasks.
// Assumes the bench feeds back the resolved SDA wire.
`timescale 1ns/1ps
module serial_host_master (
  input wire logic i_ref_clk, // Clock
  input wire logic i_miso, // SPI data in
  input wire logic i_sda, // SDA wire
  output logic o_scl, // I2C clock
  output logic o_sda, // SDA drive, 1 releases
  output logic o_sclk, // SPI clock
  output logic o_cs_n, // SPI select
  output logic o_mosi // SPI data out
);
  localparam int H = 6;
  initial
  begin
    {o_scl, o_sda, o_sclk, o_cs_n, o_mosi} = 5'h1B;
  end
  task automatic w(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  // Released data line shows no stale level
  task automatic frame(input logic on);
    w(H);
    o_cs_n = !on;
    o_mosi = !o_mosi;
    w(H);
  endtask
  task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      o_mosi = tx[i];
      w(H);
      rx[i] = i_miso;
      o_sclk = 1'b1;
      w(H);
      o_sclk = 1'b0;
    end
  endtask
  // Start when up is 0, stop when up is 1
  task automatic cond(input logic up);
    w(3);
    o_sda = !up;
    w(H);
    o_scl = 1'b1;
    w(H);
    o_sda = up;
    w(H);
    if (!up)
      o_scl = 1'b0;
  endtask
  task automatic i2c_bit(input logic b, output logic r);
    w(3);
    o_sda = b;
    w(H);
    o_scl = 1'b1;
    w(H);
    r = i_sda;
    o_scl = 1'b0;
  endtask
  task automatic i2c_byte(input logic [7:0] tx, input logic mack, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--)
      i2c_bit(tx[i], rx[i]);
    i2c_bit(mack, ack);
  endtask
endmodule // serial_host_master

// file: bench/tb.sv
// Self-checking bench for the serial register access front end.
// Assumes the host model and checker files are compiled first.
`timescale 1ns/1ps
module tb;
  localparam logic [6:0] DEV = 7'h2B; // Arbitrary bus address
  logic clk, rst, spi_mode, scl, m_sda, sclk, cs_n, mosi, miso, oe_n, sda_o, a;
  logic rd_req, rd_valid, wr_valid, wr_ready, overrun;
  logic [3:0] rd_reg, wr_reg;
  logic [1:0] rd_chan, wr_chan;
  logic [7:0] rd_data, wr_data, rcnt, d;
  logic [6:0] dev_addr;
  logic [13:0] wq[$];
  int errors, tests_run, ovr;
  wire sda_bus = m_sda & (oe_n | sda_o);
  serial_host_master host (.i_ref_clk(clk), .i_miso(miso), .i_sda(sda_bus), .o_scl(scl), .o_sda(m_sda),
    .o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi));
  serial_host_access dut (.i_ref_clk(clk), .i_rst(rst), .i_spi_mode(spi_mode), .i_dev_addr(dev_addr),
    .i_scl(scl), .i_sda(sda_bus), .o_sda(sda_o), .o_sda_oe_n(oe_n), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_mosi(mosi), .o_miso(miso), .o_rd_req(rd_req), .o_rd_reg(rd_reg), .o_rd_chan(rd_chan),
    .i_rd_valid(rd_valid), .i_rd_data(rd_data), .o_wr_valid(wr_valid), .o_wr_reg(wr_reg),
    .o_wr_chan(wr_chan), .o_wr_data(wr_data), .i_wr_ready(wr_ready), .o_overrun(overrun));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Register side answers in the same clock cycle as each request
  always @(posedge clk)
  begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1)
      wq.push_back({wr_chan, wr_reg, wr_data});
    if (overrun === 1'b1)
      ovr++;
    #1;
    rd_valid = rd_req;
    rd_data = {rd_reg, rd_chan, rcnt[1:0]};
    if (rd_req === 1'b1)
      rcnt = rcnt + 8'h01;
  end
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: byte %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_word(input logic [13:0] got, input logic [13:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: word %h want %h", $time, got, exp);
    end
  endtask
  task automatic addr(input logic [7:0] b);
    host.frame(1'b1);
    host.spi_byte(b, d);
  endtask
  task automatic t_spi_read;
    rcnt = 8'h00;
    addr(8'hAA);
    host.spi_byte(8'h00, d);
    chk_byte(d, 8'h54);
    chk_word({rd_chan, rd_reg, 8'h00}, 14'h1500);
    host.frame(1'b0);
    $display("done spi read");
  endtask
  task automatic t_spi_burst;
    rcnt = 8'h00;
    addr(8'h80);
    for (int k = 0; k < 3; k++)
    begin
      host.spi_byte(8'h00, d);
      chk_byte(d, 8'(k));
    end
    host.frame(1'b0);
    host.w(20);
    chk_byte(rcnt, 8'h04);
    $display("done spi burst read");
  endtask
  task automatic t_spi_fill;
    wr_ready = 1'b0;
    wq.delete();
    ovr = 0;
    addr(8'h02);
    for (int i = 0; i < 34; i++)
      host.spi_byte(8'(i), d);
    host.frame(1'b0);
    chk_byte({7'h00, ovr > 0}, 8'h01);
    wr_ready = 1'b1;
    host.w(80);
    chk_word(14'(wq.size() + ovr), 14'h0022);
    foreach (wq[j])
      chk_word(wq[j], {6'h10, 8'(j)});
    chk_byte({7'h00, wr_valid}, 8'h00);
    $display("done spi fifo fill");
  endtask
  task automatic t_spi_odd;
    wq.delete();
    rcnt = 8'h00;
    addr(8'h18);
    host.spi_byte(8'h5A, d);
    host.spi_byte(8'hC3, d);
    host.frame(1'b0);
    addr(8'h04);
    host.spi_byte(8'h77, d);
    host.frame(1'b0);
    addr(8'hB6);
    host.spi_byte(8'h00, d);
    host.frame(1'b0);
    chk_byte(d, 8'h00);
    chk_byte(rcnt, 8'h00);
    chk_word(14'(wq.size()), 14'h0001);
    chk_word(wq[0], 14'h035A);
    $display("done spi odd cases");
  endtask
  task automatic t_i2c;
    spi_mode = 1'b0;
    wq.delete();
    host.w(4);
    host.cond(1'b0);
    host.i2c_byte({DEV, 1'b0}, 1'b1, d, a);
    chk_byte({7'h00, a}, 8'h00);
    host.i2c_byte(8'h23, 1'b1, d, a);
    host.i2c_byte(8'h11, 1'b1, d, a);
    host.i2c_byte(8'h22, 1'b1, d, a);
    host.cond(1'b1);
    chk_word(wq[0], 14'h1411);
    chk_word(wq[1], 14'h1422);
    // Move the strapped address while idle: old one refused, new one answered
    dev_addr = ~DEV;
    host.cond(1'b0);
    host.i2c_byte({DEV, 1'b0}, 1'b1, d, a);
    host.cond(1'b1);
    chk_byte({7'h00, a}, 8'h01);
    host.cond(1'b0);
    host.i2c_byte({~DEV, 1'b0}, 1'b1, d, a);
    host.cond(1'b1);
    chk_byte({7'h00, a}, 8'h00);
    dev_addr = DEV;
    rcnt = 8'h00;
    host.cond(1'b0);
    host.i2c_byte({DEV, 1'b0}, 1'b1, d, a);
    host.i2c_byte(8'hB0, 1'b1, d, a);
    host.cond(1'b0);
    host.i2c_byte({DEV, 1'b1}, 1'b1, d, a);
    host.i2c_byte(8'hFF, 1'b0, d, a);
    chk_byte(d, 8'h60);
    host.i2c_byte(8'hFF, 1'b1, d, a);
    chk_byte(d, 8'h61);
    host.cond(1'b1);
    chk_word(14'(wq.size()), 14'h0002);
    $display("done i2c");
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    {rst, spi_mode, wr_ready, rd_valid, rd_data, rcnt} = 20'hF_0000;
    dev_addr = DEV;
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    t_spi_read();
    t_spi_burst();
    t_spi_fill();
    t_spi_odd();
    t_i2c();
    summarize();
  end
  initial
  begin
    #1000000;
    errors++;
    summarize();
  end
endmodule // tb
